// File: design/port_drive_map.vh
// Register offsets, bit masks and reset values for the port drive block
`ifndef PORT_DRIVE_MAP_VH
`define PORT_DRIVE_MAP_VH

`define OFS_A_OE_STATUS      8'h0c
`define OFS_B_OE_STATUS      8'h0d
`define OFS_C_DRIVE_SELECT   8'h16
`define OFS_D_DRIVE_SELECT   8'h17
`define OFS_C_OE_STATUS      8'h1a
`define OFS_D_OE_STATUS      8'h1b
`define OFS_PORT_CONFIG      8'h20
`define OFS_PORT_DIRECTION_A 8'h24
`define OFS_PORT_DIRECTION_B 8'h25
`define OFS_PORT_DIRECTION_C 8'h26
`define OFS_PORT_DIRECTION_D 8'h27

`define MASK_C_PINS          8'h9c
`define MASK_D_PINS          8'h06
`define MASK_LOW_NIBBLE      8'h0f
`define MASK_HIGH_NIBBLE     8'hf0
`define DRIVE_RESET          8'h00
`define CONFIG_RESET         8'h00

`define CFG_STATUS_PAIR_BIT  0
`define CFG_REPEATER_BIT     1
`define CFG_CLOCK_IN_BIT     2
`define CFG_SELECT_IN_BIT    3

`endif

// File: design/port_drive_and_output_enable.v
// Drive-type selection and output-enable readback for four I/O ports
`timescale 1ns/1ps
`include "port_drive_map.vh"

// Behaviour
// - Port C drive select: open drain bits
// - Port D drive select: slew bits 2,1
// - One selects alternative drive, zero push-pull
// - Drive select registers reset to zero
// - Port A/B enable-out, bit per pin
// - Port C/D enable-out, valid bits only
// - Enable-out one when driving, zero input
// - Enable-out reports final combined enable
// - Port A five pin modes
// - Port A slew low, open drain high
// - Port B modes, two macrocell banks
// - Port B slew low, open drain high
// - Port C modes on pins 2,3,4,7
// - Status/error pins enabled only together
// - Pin C3 shows ready/busy
// - Pin C4 shows backup supply switchover
// - Test-access pins never general I/O
// - Port D I/O, selects, direct input
// - Pin D1 clock for macrocells, power-down
module port_drive_and_output_enable (
  input  wire        mclk,
  input  wire        arst_n,
  input  wire [7:0]  addr,
  input  wire [7:0]  wdata,
  input  wire        wr_stb,
  input  wire        rd_stb,
  output reg  [7:0]  rdata,
  // Port A/B drive select lives elsewhere; applied here per pin capability
  input  wire [7:0]  port_a_drive_select,
  input  wire [7:0]  port_b_drive_select,
  // Per-port mode sources
  input  wire [7:0]  port_a_mode_reg,
  input  wire [7:0]  port_a_mode_addr,
  input  wire [7:0]  port_a_mode_cell,
  input  wire [7:0]  port_b_mode_reg,
  input  wire [7:0]  port_b_mode_addr,
  input  wire [7:0]  port_b_mode_cell,
  input  wire [7:0]  port_b_bank_sel,
  input  wire [7:0]  port_c_mode_reg,
  input  wire [7:0]  port_c_mode_cell,
  input  wire [7:0]  port_d_mode_reg,
  input  wire [7:0]  port_d_mode_select,
  // Data sources
  input  wire [7:0]  port_a_reg_out,
  input  wire [7:0]  port_b_reg_out,
  input  wire [7:0]  port_c_reg_out,
  input  wire [7:0]  port_d_reg_out,
  input  wire [7:0]  latched_addr_a,
  input  wire [7:0]  latched_addr_b,
  input  wire [7:0]  macrocell_bank_one_output,
  input  wire [7:0]  macrocell_bank_two_output,
  input  wire [7:0]  output_macrocell_oe_a,
  input  wire [7:0]  output_macrocell_oe_b,
  input  wire [7:0]  output_macrocell_oe_c,
  input  wire        external_select_one,
  input  wire        external_select_two,
  input  wire [7:0]  repeater_data_out,
  input  wire        repeater_active,
  input  wire        repeater_drive_out,
  input  wire        flash_ready,
  input  wire        sram_on_backup,
  // Pin inputs
  input  wire [7:0]  port_a_pin_in,
  input  wire [7:0]  port_b_pin_in,
  input  wire [7:0]  port_c_pin_in,
  input  wire [7:0]  port_d_pin_in,
  // Pin outputs, enables and drive types
  output reg  [7:0]  port_a_pin_out,
  output reg  [7:0]  port_a_pin_oe,
  output reg  [7:0]  port_a_open_drain,
  output reg  [7:0]  port_a_fast_slew,
  output reg  [7:0]  port_b_pin_out,
  output reg  [7:0]  port_b_pin_oe,
  output reg  [7:0]  port_b_open_drain,
  output reg  [7:0]  port_b_fast_slew,
  output reg  [7:0]  port_c_pin_out,
  output reg  [7:0]  port_c_pin_oe,
  output reg  [7:0]  port_c_open_drain,
  output reg  [7:0]  port_d_pin_out,
  output reg  [7:0]  port_d_pin_oe,
  output reg  [7:0]  port_d_fast_slew,
  // Inputs delivered to logic arrays and dedicated functions
  output reg  [7:0]  input_macrocell_a,
  output reg  [7:0]  input_macrocell_b,
  output reg  [7:0]  input_macrocell_c,
  output reg  [1:0]  logic_array_direct_in,
  output reg         output_macrocell_clock,
  output reg         auto_power_down_clock,
  output reg         memory_standby_force
);

  ////////////////////////////////////////////////////////////////////////////
  // Register storage

  reg  [7:0] c_drive_q;
  reg  [7:0] d_drive_q;
  reg  [7:0] config_q;
  reg  [7:0] dir_a_q;
  reg  [7:0] dir_b_q;
  reg  [7:0] dir_c_q;
  reg  [7:0] dir_d_q;

  reg  [7:0] oe_a_d;
  reg  [7:0] oe_b_d;
  reg  [7:0] oe_c_d;
  reg  [7:0] oe_d_d;
  reg  [7:0] out_a_d;
  reg  [7:0] out_b_d;
  reg  [7:0] out_c_d;
  reg  [7:0] out_d_d;
  reg  [7:0] rdata_d;

  wire status_pair_en = config_q[`CFG_STATUS_PAIR_BIT];
  wire repeater_en    = config_q[`CFG_REPEATER_BIT];
  wire clock_in_en    = config_q[`CFG_CLOCK_IN_BIT];
  wire select_in_en   = config_q[`CFG_SELECT_IN_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Pin capability decode

  // Port C pins with general modes; the others belong to the test port
  function c_general_pin;
    input integer idx;
    begin
      c_general_pin = ((`MASK_C_PINS >> idx) & 8'h01) != 8'h00;
    end
  endfunction

  // Port D pins that have a pad; bit 0 and bits 7..3 do not
  function d_present_pin;
    input integer idx;
    begin
      d_present_pin = ((`MASK_D_PINS >> idx) & 8'h01) != 8'h00;
    end
  endfunction

  // Writes to enable-out offsets fall through the case untouched
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      c_drive_q <= `DRIVE_RESET;
      d_drive_q <= `DRIVE_RESET;
      config_q  <= `CONFIG_RESET;
      dir_a_q   <= 8'h00;
      dir_b_q   <= 8'h00;
      dir_c_q   <= 8'h00;
      dir_d_q   <= 8'h00;
    end else if (wr_stb) begin
      case (addr)
        `OFS_C_DRIVE_SELECT: begin
          c_drive_q <= wdata & `MASK_C_PINS;
        end
        `OFS_D_DRIVE_SELECT: begin
          d_drive_q <= wdata & `MASK_D_PINS;
        end
        `OFS_PORT_CONFIG: begin
          config_q  <= wdata & 8'h0f;
        end
        `OFS_PORT_DIRECTION_A: begin
          dir_a_q   <= wdata;
        end
        `OFS_PORT_DIRECTION_B: begin
          dir_b_q   <= wdata;
        end
        `OFS_PORT_DIRECTION_C: begin
          dir_c_q   <= wdata & `MASK_C_PINS;
        end
        `OFS_PORT_DIRECTION_D: begin
          dir_d_q   <= wdata & `MASK_D_PINS;
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-pin data and output-enable muxing

  integer i;
  always @* begin
    for (i = 0; i < 8; i = i + 1) begin
      // Port A: repeater overrides every other mode on the whole port
      if (repeater_en) begin
        out_a_d[i] = repeater_data_out[i];
        oe_a_d[i]  = repeater_active & repeater_drive_out;
      end else if (port_a_mode_addr[i]) begin
        out_a_d[i] = latched_addr_a[i];
        oe_a_d[i]  = 1'b1;
      end else if (port_a_mode_cell[i]) begin
        out_a_d[i] = macrocell_bank_one_output[i];
        oe_a_d[i]  = output_macrocell_oe_a[i];
      end else if (port_a_mode_reg[i]) begin
        out_a_d[i] = port_a_reg_out[i];
        oe_a_d[i]  = dir_a_q[i];
      end else begin
        out_a_d[i] = 1'b0;
        oe_a_d[i]  = 1'b0;
      end
      // Port B: allocator picks one of two banks
      if (port_b_mode_addr[i]) begin
        out_b_d[i] = latched_addr_b[i];
        oe_b_d[i]  = 1'b1;
      end else if (port_b_mode_cell[i]) begin
        out_b_d[i] = port_b_bank_sel[i] ? macrocell_bank_two_output[i]
                                        : macrocell_bank_one_output[i];
        oe_b_d[i]  = output_macrocell_oe_b[i];
      end else if (port_b_mode_reg[i]) begin
        out_b_d[i] = port_b_reg_out[i];
        oe_b_d[i]  = dir_b_q[i];
      end else begin
        out_b_d[i] = 1'b0;
        oe_b_d[i]  = 1'b0;
      end
    end
    // Port C: general modes on pins 2,3,4,7 only
    for (i = 0; i < 8; i = i + 1) begin
      if (!c_general_pin(i)) begin
        out_c_d[i] = 1'b0;
        oe_c_d[i]  = 1'b0;
      end else if (port_c_mode_cell[i]) begin
        out_c_d[i] = macrocell_bank_two_output[i];
        oe_c_d[i]  = output_macrocell_oe_c[i];
      end else if (port_c_mode_reg[i]) begin
        out_c_d[i] = port_c_reg_out[i];
        oe_c_d[i]  = dir_c_q[i];
      end else begin
        out_c_d[i] = 1'b0;
        oe_c_d[i]  = 1'b0;
      end
    end
    // Status pair takes both pins together and shuts out other modes
    if (status_pair_en) begin
      out_c_d[3] = flash_ready;
      oe_c_d[3]  = 1'b1;
      out_c_d[4] = sram_on_backup;
      oe_c_d[4]  = 1'b1;
    end
    // Test-access pins are never driven from here
    out_c_d = out_c_d & `MASK_C_PINS;
    oe_c_d  = oe_c_d & `MASK_C_PINS;
    // Port D: pins 1 and 2 only
    out_d_d = 8'h00;
    oe_d_d  = 8'h00;
    for (i = 0; i < 8; i = i + 1) begin
      if (!d_present_pin(i)) begin
        out_d_d[i] = 1'b0;
        oe_d_d[i]  = 1'b0;
      end else if (port_d_mode_select[i]) begin
        out_d_d[i] = (i == 1) ? external_select_one : external_select_two;
        oe_d_d[i]  = 1'b1;
      end else if (port_d_mode_reg[i]) begin
        out_d_d[i] = port_d_reg_out[i];
        oe_d_d[i]  = dir_d_q[i];
      end
    end
    // Dedicated inputs force the pin undriven
    if (clock_in_en) oe_d_d[1] = 1'b0;
    if (select_in_en) oe_d_d[2] = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read mux, one cycle latency

  // Registered pin enables are read, so a mode change shows two cycles late
  always @* begin
    case (addr)
      `OFS_A_OE_STATUS: begin
        rdata_d = port_a_pin_oe;
      end
      `OFS_B_OE_STATUS: begin
        rdata_d = port_b_pin_oe;
      end
      `OFS_C_OE_STATUS: begin
        rdata_d = port_c_pin_oe & `MASK_C_PINS;
      end
      `OFS_D_OE_STATUS: begin
        rdata_d = port_d_pin_oe & `MASK_D_PINS;
      end
      `OFS_C_DRIVE_SELECT: begin
        rdata_d = c_drive_q;
      end
      `OFS_D_DRIVE_SELECT: begin
        rdata_d = d_drive_q;
      end
      `OFS_PORT_CONFIG: begin
        rdata_d = config_q;
      end
      `OFS_PORT_DIRECTION_A: begin
        rdata_d = dir_a_q;
      end
      `OFS_PORT_DIRECTION_B: begin
        rdata_d = dir_b_q;
      end
      `OFS_PORT_DIRECTION_C: begin
        rdata_d = dir_c_q;
      end
      `OFS_PORT_DIRECTION_D: begin
        rdata_d = dir_d_q;
      end
      default: begin
        rdata_d = 8'h00;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output flops: pins, drive types, dedicated inputs

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rdata                  <= 8'h00;
      port_a_pin_out         <= 8'h00;
      port_a_pin_oe          <= 8'h00;
      port_a_open_drain      <= 8'h00;
      port_a_fast_slew       <= 8'h00;
      port_b_pin_out         <= 8'h00;
      port_b_pin_oe          <= 8'h00;
      port_b_open_drain      <= 8'h00;
      port_b_fast_slew       <= 8'h00;
      port_c_pin_out         <= 8'h00;
      port_c_pin_oe          <= 8'h00;
      port_c_open_drain      <= 8'h00;
      port_d_pin_out         <= 8'h00;
      port_d_pin_oe          <= 8'h00;
      port_d_fast_slew       <= 8'h00;
      input_macrocell_a      <= 8'h00;
      input_macrocell_b      <= 8'h00;
      input_macrocell_c      <= 8'h00;
      logic_array_direct_in  <= 2'b00;
      output_macrocell_clock <= 1'b0;
      auto_power_down_clock  <= 1'b0;
      memory_standby_force   <= 1'b0;
    end else begin
      // Idle bus reads zero so stale data never lingers
      if (rd_stb) begin
        rdata <= rdata_d;
      end else begin
        rdata <= 8'h00;
      end
      port_a_pin_out <= out_a_d;
      port_a_pin_oe  <= oe_a_d;
      port_b_pin_out <= out_b_d;
      port_b_pin_oe  <= oe_b_d;
      port_c_pin_out <= out_c_d;
      port_c_pin_oe  <= oe_c_d;
      port_d_pin_out <= out_d_d;
      port_d_pin_oe  <= oe_d_d;
      // Capability masking: a set bit without the option stays push-pull
      port_a_open_drain <= port_a_drive_select & `MASK_HIGH_NIBBLE;
      port_a_fast_slew  <= port_a_drive_select & `MASK_LOW_NIBBLE;
      port_b_open_drain <= port_b_drive_select & `MASK_HIGH_NIBBLE;
      port_b_fast_slew  <= port_b_drive_select & `MASK_LOW_NIBBLE;
      port_c_open_drain <= c_drive_q;
      port_d_fast_slew  <= d_drive_q;
      input_macrocell_a <= port_a_pin_in;
      input_macrocell_b <= port_b_pin_in;
      input_macrocell_c <= port_c_pin_in & `MASK_C_PINS;
      logic_array_direct_in  <= port_d_pin_in[2:1];
      output_macrocell_clock <= clock_in_en & port_d_pin_in[1];
      auto_power_down_clock  <= clock_in_en & port_d_pin_in[1];
      // Relies on the outside source holding the pin high for standby
      memory_standby_force   <= select_in_en & port_d_pin_in[2];
    end
  end

endmodule

// File: bench/port_drive_props.sv
// Concurrent checks on register reads, port C drive type and port C/D enables
`timescale 1ns/1ps
module port_drive_props (
  input logic       mclk,
  input logic       arst_n,
  input logic [7:0] addr,
  input logic [7:0] wdata,
  input logic       wr_stb,
  input logic       rd_stb,
  input logic [7:0] rdata,
  input logic [7:0] port_c_open_drain,
  input logic [7:0] port_c_pin_oe,
  input logic [7:0] port_c_pin_out,
  input logic [7:0] port_d_pin_oe,
  input logic       flash_ready,
  input logic       sram_on_backup
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////////////////
  // Private config register is not a port, so it is mirrored here
  logic [3:0] cfg_q;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n)
      cfg_q <= 4'h0;
    else if (wr_stb && addr == 8'h20)
      cfg_q <= wdata[3:0];
  end
  ////////////////////////////////////////////////////////////////////////////
  a_cdrive_apply:
    assert property (wr_stb && addr == 8'h16 ##1 !(wr_stb && addr == 8'h16)
      |=> port_c_open_drain == ($past(wdata, 2) & 8'h9c)) else $error("c drive type");
  a_reset_clear:
    assert property ($rose(arst_n) |=> port_c_open_drain == 8'h00 && rdata == 8'h00)
      else $error("reset state");
  // Only judged when the enable did not move across the read edge
  a_cstatus_read:
    assert property (rd_stb && addr == 8'h1a |=> !$stable(port_c_pin_oe)
      || rdata == (port_c_pin_oe & 8'h9c)) else $error("c enable read");
  a_dstatus_read:
    assert property (rd_stb && addr == 8'h1b |=> !$stable(port_d_pin_oe)
      || rdata == (port_d_pin_oe & 8'h06)) else $error("d enable read");
  a_test_pins:
    assert property (((port_c_pin_oe | port_c_open_drain) & 8'h63) == 8'h00
      && (port_d_pin_oe & 8'hf9) == 8'h00) else $error("test pin used");
  a_status_pair:
    assert property ($past(cfg_q[0]) |-> port_c_pin_oe[4:3] == 2'b11
      && port_c_pin_out[4:3] == {$past(sram_on_backup), $past(flash_ready)})
      else $error("status pair");
  a_unmapped_read:
    assert property (rd_stb && !(addr inside {8'h0c, 8'h0d, 8'h16, 8'h17, 8'h1a, 8'h1b,
      8'h20, [8'h24:8'h27]}) |=> rdata == 8'h00) else $error("unmapped read");
  a_idle_rdata:
    assert property (!rd_stb |=> rdata == 8'h00) else $error("rdata not idle");
endmodule

// File: bench/pin_pad.sv
// External circuits on all 32 port pins: weak pull-ups plus optional drivers
`timescale 1ns/1ps
module pin_pad (
  input  logic [31:0] out,
  input  logic [31:0] oe,
  input  logic [31:0] od,
  input  logic [31:0] xoe,
  input  logic [31:0] xv,
  output logic [31:0] pin
);
  // Open drain only sinks; a released line follows an enabled outside driver, else rises to the pull-up, never holds
  always_comb
    for (int i = 0; i < 32; i++)
      pin[i] = (oe[i] && !(od[i] && out[i])) ? out[i] : (xoe[i] ? xv[i] : 1'b1);
endmodule

// File: bench/tb.sv
// Self-checking bench for the port drive and output-enable block
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  reg         mclk, arst_n, wr_stb, rd_stb, fr, sb;
  reg  [7:0]  addr, wdata, ma, mc, ms, sv;
  reg  [31:0] xoe, xv;
  reg  [27:0] rows [0:21];
  wire [31:0] po, pe, pod, pin;
  wire [7:0]  rdata, afs, bfs, dfs, ima, imb, input_macrocell;
  wire [1:0]  ldi;
  wire        oclk, aclk, msf;
  int         failures, n_tests, cnt;
  assign pod[7:0] = 8'h00;
  port_drive_and_output_enable dut (
    .mclk(mclk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .port_a_drive_select(ms), .port_b_drive_select(~ms),
    .port_a_mode_reg(ma), .port_a_mode_addr(mc & 8'h0f), .port_a_mode_cell(mc & 8'hf0),
    .port_b_mode_reg(ma), .port_b_mode_addr(mc & 8'h0f), .port_b_mode_cell(mc & 8'hf0),
    .port_b_bank_sel(sv), .port_c_mode_reg(ma), .port_c_mode_cell(mc),
    .port_d_mode_reg(ma), .port_d_mode_select(mc), .port_a_reg_out(sv), .port_b_reg_out(sv),
    .port_c_reg_out(sv), .port_d_reg_out(sv), .latched_addr_a(~sv), .latched_addr_b(~sv),
    .macrocell_bank_one_output(sv), .macrocell_bank_two_output(~sv),
    .output_macrocell_oe_a(sv), .output_macrocell_oe_b(sv), .output_macrocell_oe_c(sv),
    .external_select_one(sv[1]), .external_select_two(sv[2]), .repeater_data_out(sv),
    .repeater_active(fr), .repeater_drive_out(sb), .flash_ready(fr), .sram_on_backup(sb),
    .port_a_pin_in(pin[31:24]), .port_b_pin_in(pin[23:16]), .port_c_pin_in(pin[15:8]),
    .port_d_pin_in(pin[7:0]), .port_a_pin_out(po[31:24]), .port_a_pin_oe(pe[31:24]),
    .port_a_open_drain(pod[31:24]), .port_a_fast_slew(afs), .port_b_pin_out(po[23:16]),
    .port_b_pin_oe(pe[23:16]), .port_b_open_drain(pod[23:16]), .port_b_fast_slew(bfs),
    .port_c_pin_out(po[15:8]), .port_c_pin_oe(pe[15:8]), .port_c_open_drain(pod[15:8]),
    .port_d_pin_out(po[7:0]), .port_d_pin_oe(pe[7:0]), .port_d_fast_slew(dfs),
    .input_macrocell_a(ima), .input_macrocell_b(imb), .input_macrocell_c(input_macrocell),
    .logic_array_direct_in(ldi), .output_macrocell_clock(oclk),
    .auto_power_down_clock(aclk), .memory_standby_force(msf));
  pin_pad pads (.out(po), .oe(pe), .od(pod), .xoe(xoe), .xv(xv), .pin(pin));
  ////////////////////////////////////////////////////////////////////////////
  task results;
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    wr_stb <= w;
    rd_stb <= !w;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr_stb <= 1'b0;
    rd_stb <= 1'b0;
    @(negedge mclk);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    `CHK(rdata, e)
  endtask
  task wt(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cnt++;
    if (cnt == 3000) begin
      failures++;
      results();
    end
  end
  initial begin
    {arst_n, wr_stb, rd_stb, fr, sb} = 5'b0;
    {addr, wdata, mc, ms} = 32'h0;
    {xoe, xv} = 64'h0;
    ma = 8'hff;
    sv = 8'h5a;
    // Kind nibble (1 write), address, write data, expected read data
    rows = '{28'h0160000, 28'h116ff00, 28'h016009c, 28'h117ff00, 28'h0170006, 28'h124a500,
      28'h00c00a5, 28'h1253c00, 28'h00d003c, 28'h126ff00, 28'h01a009c, 28'h127ff00,
      28'h01b0006, 28'h10c0000, 28'h00c00a5, 28'h11b0000, 28'h01b0006, 28'h0300000,
      28'h120f000, 28'h0200000, 28'h130ff00, 28'h0170006};
    repeat (20) @(posedge mclk);
    arst_n <= 1'b1;
    foreach (rows[i]) begin
      bus(rows[i][24], rows[i][23:16], rows[i][15:8]);
      if (!rows[i][24])
        `CHK(rdata, rows[i][7:0])
    end
    @(posedge mclk);
    ms <= 8'h3c;
    wt(2);
    `CHK({pod[31:24], afs, pod[23:16], bfs}, 32'h300cc003)
    `CHK({pod[15:8], dfs}, 16'h9c06)
    bus(1'b1, 8'h16, 8'h00);
    wt(2);
    `CHK(pod[15:8], 8'h00)
    @(posedge mclk);
    mc <= 8'hff;
    wt(2);
    rd(8'h0c, 8'h5f);
    rd(8'h0d, 8'h5f);
    rd(8'h1a, 8'h18);
    rd(8'h1b, 8'h06);
    `CHK({po[31:16], po[2:1]}, 18'h15415)
    @(posedge mclk);
    fr <= 1'b1;
    sb <= 1'b1;
    bus(1'b1, 8'h20, 8'h02);
    wt(2);
    rd(8'h0c, 8'hff);
    `CHK(po[31:24], 8'h5a)
    @(posedge mclk);
    mc <= 8'h00;
    fr <= 1'b0;
    xoe <= 32'h6;
    xv <= 32'h6;
    bus(1'b1, 8'h27, 8'h00);
    bus(1'b1, 8'h20, 8'h0d);
    wt(2);
    `CHK({pe[12:11], po[12:11]}, 4'b1110)
    `CHK({oclk, aclk, msf, ldi}, 5'b11111)
    `CHK({ima, imb, input_macrocell}, 24'h5adb10)
    @(posedge mclk);
    xv <= 32'h0;
    wt(2);
    `CHK({oclk, aclk, msf, ldi}, 5'b00000)
    @(posedge mclk);
    arst_n <= 1'b0;
    wt(3);
    `CHK(pod[15:8] | dfs | rdata, 8'h00)
    @(posedge mclk);
    arst_n <= 1'b1;
    rd(8'h17, 8'h00);
    rd(8'h20, 8'h00);
    results();
  end
endmodule
bind port_drive_and_output_enable port_drive_props props (.*);
